// File: rtl/spimsp_defines.svh
// Register map, field positions, reset values and clock divider figures of the SPI port
`ifndef SPIMSP_DEFINES_SVH
`define SPIMSP_DEFINES_SVH

`define SPIMSP_OFS_CONTROL 4'h0
`define SPIMSP_OFS_STATUS 4'h4
`define SPIMSP_OFS_DATA 4'h8
`define SPIMSP_OFS_PINCFG 4'hc

`define SPIMSP_CTL_IRQ_EN 7
`define SPIMSP_CTL_PORT_EN 6
`define SPIMSP_CTL_LSB_FIRST 5
`define SPIMSP_CTL_MASTER 4
`define SPIMSP_CTL_CLOCK_POLARITY 3
`define SPIMSP_CTL_CLOCK_PHASE 2
`define SPIMSP_CTL_RATE_HI 1
`define SPIMSP_CTL_RATE_LO 0

`define SPIMSP_STS_DONE 7
`define SPIMSP_STS_WRITE_COLLISION_FLAG 6
`define SPIMSP_STS_DSPEED 0

`define SPIMSP_PIN_MISO_OUT 0
`define SPIMSP_PIN_MOSI_OUT 1
`define SPIMSP_PIN_SCK_OUT 2
`define SPIMSP_PIN_SS_OUT 3
`define SPIMSP_PIN_SS_LEVEL 4

`define SPIMSP_RST_CONTROL 8'h00
`define SPIMSP_RST_PINCFG 5'h00
`define SPIMSP_RST_DATA 8'h00

// Half SCK periods in system clocks, index {double_speed, rate_hi, rate_lo}
`define SPIMSP_HALF_DIV4 7'h02
`define SPIMSP_HALF_DIV16 7'h08
`define SPIMSP_HALF_DIV64 7'h20
`define SPIMSP_HALF_DIV128 7'h40
`define SPIMSP_HALF_DIV2 7'h01
`define SPIMSP_HALF_DIV8 7'h04
`define SPIMSP_HALF_DIV32 7'h10

`define SPIMSP_LAST_EDGE 4'hf

// Longest master byte in system clocks, 16 edges at the slowest half period
`define SPIMSP_MSHIFT_MAX 11'h400

`endif

// File: rtl/spimsp_pkg.sv
// Types shared by the SPI port modules
package spimsp_pkg;
    typedef enum logic [1:0] {
        SM_IDLE,
        SM_MSHIFT,
        SM_SLAVE
    } spimsp_state_t;
    typedef logic [7:0] spimsp_byte_t;
endpackage

// File: rtl/spimsp_sync.sv
// Two-stage synchroniser for a group of pin levels
module spimsp_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic [W-1:0] i_d,
    output logic [W-1:0] o_q
);
    logic [W-1:0] meta_r;

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            meta_r <= INIT;
            o_q <= INIT;
        end else begin
            meta_r <= i_d;
            o_q <= meta_r;
        end
    end
endmodule

// File: rtl/spimsp_port.sv
// SPI master/slave port with Avalon-MM register access
//
// Decided for this implementation: the address map and the Avalon-MM register port.
`include "spimsp_defines.svh"

module spimsp_port (
    input wire logic I_CLK,
    input wire logic I_NRST,
    input wire logic [3:0] I_AVS_ADDRESS,
    input wire logic I_AVS_READ,
    input wire logic I_AVS_WRITE,
    input wire logic [31:0] I_AVS_WRITEDATA,
    input wire logic [3:0] I_AVS_BYTEENABLE,
    output logic [31:0] O_AVS_READDATA,
    output logic O_AVS_WAITREQUEST,
    input wire logic I_IRQ_ACK,
    output logic O_IRQ,
    input wire logic I_SCK,
    output logic O_SCK,
    output logic O_SCK_OE_N,
    input wire logic I_MOSI,
    output logic O_MOSI,
    output logic O_MOSI_OE_N,
    input wire logic I_MISO,
    output logic O_MISO,
    output logic O_MISO_OE_N,
    input wire logic I_SS_N,
    output logic O_SS_N,
    output logic O_SS_OE_N,
    output spimsp_pkg::spimsp_byte_t O_RX_BYTE
);
    import spimsp_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Declarations
    spimsp_state_t st_r;
    spimsp_byte_t ctrl_r;
    spimsp_byte_t sr_r;
    spimsp_byte_t rx_buf_r;
    logic [4:0] pincfg_r;
    logic dspeed_r;
    logic done_r;
    logic write_collision_flag_r;
    logic arm_done_r;
    logic arm_write_collision_flag_r;
    logic rd_ack_r;
    logic [31:0] rdata_r;
    logic sck_r;
    logic sck_prev_r;
    logic samp_r;
    logic [3:0] edge_cnt_r;
    logic [6:0] div_cnt_r;
    logic [2:0] pins_s;
    logic sck_s;
    logic mosi_s;
    logic ss_s;
    logic en;
    logic master_select;
    logic clock_polarity;
    logic clock_phase;
    logic lsb_first;
    logic rd_take;
    logic wr_take;
    logic wr_lane;
    logic data_acc;
    logic data_wr;
    logic busy;
    logic mfault;
    logic edge_ev;
    logic sample_in;
    logic is_sample;
    logic last_edge;
    logic complete;
    logic start;
    logic [6:0] half;

    function automatic spimsp_byte_t shift_in(input spimsp_byte_t v, input logic b, input logic lsb);
        shift_in = lsb ? {b, v[7:1]} : {v[6:0], b};
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    // The external master must respect the SCK rate and phase widths for these to see every edge.
    spimsp_sync #(
        .W(3),
        .INIT(3'h1)
    ) u_sync (
        .i_clk(I_CLK),
        .i_nrst(I_NRST),
        .i_d({I_MOSI, I_SCK, I_SS_N}),
        .o_q(pins_s)
    );
    assign mosi_s = pins_s[2];
    assign sck_s = pins_s[1];
    assign ss_s = pins_s[0];

    ////////////////////////////////////////////////////////////////////////////
    // Decode of control and bus strobes
    assign en = ctrl_r[`SPIMSP_CTL_PORT_EN];
    assign master_select = ctrl_r[`SPIMSP_CTL_MASTER];
    assign clock_polarity = ctrl_r[`SPIMSP_CTL_CLOCK_POLARITY];
    assign clock_phase = ctrl_r[`SPIMSP_CTL_CLOCK_PHASE];
    assign lsb_first = ctrl_r[`SPIMSP_CTL_LSB_FIRST];

    assign O_AVS_WAITREQUEST = I_AVS_READ & ~rd_ack_r;
    assign rd_take = I_AVS_READ & rd_ack_r;
    assign wr_take = I_AVS_WRITE;
    assign wr_lane = wr_take & I_AVS_BYTEENABLE[0];
    assign data_acc = (I_AVS_ADDRESS == `SPIMSP_OFS_DATA) & (rd_take | wr_take);
    assign data_wr = wr_lane & (I_AVS_ADDRESS == `SPIMSP_OFS_DATA);

    assign busy = (st_r == SM_MSHIFT) || (st_r == SM_SLAVE && edge_cnt_r != 4'h0);
    assign start = data_wr & ~busy & en & master_select & ~mfault & (st_r == SM_IDLE);
    assign mfault = en & master_select & ~pincfg_r[`SPIMSP_PIN_SS_OUT] & ~ss_s;

    always_comb begin
        // Rate bits only reach the divider; slave timing ignores them
        case ({dspeed_r, ctrl_r[`SPIMSP_CTL_RATE_HI], ctrl_r[`SPIMSP_CTL_RATE_LO]})
            3'h0: half = `SPIMSP_HALF_DIV4;
            3'h1: half = `SPIMSP_HALF_DIV16;
            3'h2: half = `SPIMSP_HALF_DIV64;
            3'h3: half = `SPIMSP_HALF_DIV128;
            3'h4: half = `SPIMSP_HALF_DIV2;
            3'h5: half = `SPIMSP_HALF_DIV8;
            3'h6: half = `SPIMSP_HALF_DIV32;
            default: half = `SPIMSP_HALF_DIV64;
        endcase
    end

    always_comb begin
        edge_ev = 1'b0;
        sample_in = I_MISO;
        case (st_r)
            SM_MSHIFT: begin
                edge_ev = (div_cnt_r == 7'h00);
            end
            SM_SLAVE: begin
                edge_ev = ~ss_s & (sck_s != sck_prev_r);
                sample_in = mosi_s;
            end
            default: begin
                edge_ev = 1'b0;
            end
        endcase
    end
    // Even edges lead; phase picks which kind samples
    assign is_sample = (edge_cnt_r[0] == clock_phase);
    assign last_edge = (edge_cnt_r == `SPIMSP_LAST_EDGE);
    assign complete = edge_ev & last_edge;

    ////////////////////////////////////////////////////////////////////////////
    // Transfer state
    always_ff @(posedge I_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            st_r <= SM_IDLE;
        end else begin
            case (st_r)
                SM_IDLE: begin
                    if (start) begin
                        st_r <= SM_MSHIFT;
                    end else if (en & ~master_select & ~ss_s) begin
                        st_r <= SM_SLAVE;
                    end
                end
                SM_MSHIFT: begin
                    if (~en | mfault | complete) begin
                        st_r <= SM_IDLE;
                    end
                end
                SM_SLAVE: begin
                    if (~en | master_select | ss_s) begin
                        st_r <= SM_IDLE;
                    end
                end
                default: begin
                    st_r <= SM_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge I_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            edge_cnt_r <= 4'h0;
        end else if (st_r == SM_IDLE || (st_r == SM_SLAVE && (ss_s | ~en | master_select)) || mfault) begin
            edge_cnt_r <= 4'h0;
        end else if (edge_ev) begin
            edge_cnt_r <= edge_cnt_r + 4'h1;
        end
    end

    always_ff @(posedge I_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            div_cnt_r <= 7'h00;
        end else if (start || (st_r == SM_MSHIFT && div_cnt_r == 7'h00)) begin
            div_cnt_r <= half - 7'h01;
        end else if (st_r == SM_MSHIFT) begin
            div_cnt_r <= div_cnt_r - 7'h01;
        end
    end

    always_ff @(posedge I_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            sck_r <= 1'b0;
        end else if (st_r == SM_MSHIFT && edge_ev && !complete) begin
            sck_r <= ~sck_r;
        end else if (st_r != SM_MSHIFT || complete) begin
            sck_r <= clock_polarity;
        end
    end

    always_ff @(posedge I_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            sck_prev_r <= 1'b0;
        end else begin
            sck_prev_r <= sck_s;
        end
    end

    // Shift register doubles as the single transmit buffer
    always_ff @(posedge I_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            sr_r <= `SPIMSP_RST_DATA;
            samp_r <= 1'b0;
        end else if (data_wr && !busy) begin
            sr_r <= I_AVS_WRITEDATA[7:0];
        end else if (edge_ev) begin
            if (is_sample) begin
                samp_r <= sample_in;
                // A master keeps MOSI still on its own sampling edge
                if (last_edge && st_r == SM_SLAVE) begin
                    sr_r <= shift_in(sr_r, sample_in, lsb_first);
                end
            end else if (!(clock_phase && edge_cnt_r == 4'h0)) begin
                sr_r <= shift_in(sr_r, samp_r, lsb_first);
            end
        end
    end

    always_ff @(posedge I_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            rx_buf_r <= `SPIMSP_RST_DATA;
        end else if (complete) begin
            rx_buf_r <= clock_phase ? shift_in(sr_r, sample_in, lsb_first) : shift_in(sr_r, samp_r, lsb_first);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Control, pin configuration and flags
    always_ff @(posedge I_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            ctrl_r <= `SPIMSP_RST_CONTROL;
        end else if (mfault) begin
            ctrl_r[`SPIMSP_CTL_MASTER] <= 1'b0;
        end else if (wr_lane && I_AVS_ADDRESS == `SPIMSP_OFS_CONTROL) begin
            ctrl_r <= I_AVS_WRITEDATA[7:0];
        end
    end

    always_ff @(posedge I_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            pincfg_r <= `SPIMSP_RST_PINCFG;
            dspeed_r <= 1'b0;
        end else if (wr_lane && I_AVS_ADDRESS == `SPIMSP_OFS_PINCFG) begin
            pincfg_r <= I_AVS_WRITEDATA[4:0];
        end else if (wr_lane && I_AVS_ADDRESS == `SPIMSP_OFS_STATUS) begin
            dspeed_r <= I_AVS_WRITEDATA[`SPIMSP_STS_DSPEED];
        end
    end

    always_ff @(posedge I_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            arm_done_r <= 1'b0;
            arm_write_collision_flag_r <= 1'b0;
        end else if (rd_take && I_AVS_ADDRESS == `SPIMSP_OFS_STATUS) begin
            arm_done_r <= rdata_r[`SPIMSP_STS_DONE];
            arm_write_collision_flag_r <= rdata_r[`SPIMSP_STS_WRITE_COLLISION_FLAG];
        end else if (data_acc) begin
            arm_done_r <= 1'b0;
            arm_write_collision_flag_r <= 1'b0;
        end
    end

    // A new event in the clearing cycle wins over the clear
    always_ff @(posedge I_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            done_r <= 1'b0;
        end else if (complete || mfault) begin
            done_r <= 1'b1;
        end else if (I_IRQ_ACK || (data_acc && (arm_done_r || arm_write_collision_flag_r))) begin
            done_r <= 1'b0;
        end
    end

    always_ff @(posedge I_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            write_collision_flag_r <= 1'b0;
        end else if (data_wr && busy) begin
            write_collision_flag_r <= 1'b1;
        end else if (data_acc && arm_write_collision_flag_r) begin
            write_collision_flag_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Avalon read path, one wait state
    always_ff @(posedge I_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            rd_ack_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
        end else begin
            rd_ack_r <= I_AVS_READ & ~rd_ack_r;
            if (I_AVS_READ && !rd_ack_r) begin
                if (I_AVS_ADDRESS == `SPIMSP_OFS_CONTROL) begin
                    rdata_r <= {24'h00_0000, ctrl_r};
                end else if (I_AVS_ADDRESS == `SPIMSP_OFS_STATUS) begin
                    rdata_r <= {24'h00_0000, done_r, write_collision_flag_r, 5'h00, dspeed_r};
                end else if (I_AVS_ADDRESS == `SPIMSP_OFS_DATA) begin
                    rdata_r <= {24'h00_0000, rx_buf_r};
                end else if (I_AVS_ADDRESS == `SPIMSP_OFS_PINCFG) begin
                    rdata_r <= {27'h000_0000, pincfg_r};
                end else begin
                    rdata_r <= 32'h0000_0000;
                end
            end
        end
    end
    assign O_AVS_READDATA = rdata_r;

    ////////////////////////////////////////////////////////////////////////////
    // Outputs
    assign O_IRQ = done_r & ctrl_r[`SPIMSP_CTL_IRQ_EN];
    assign O_RX_BYTE = rx_buf_r;
    assign O_SCK = sck_r;
    assign O_MOSI = lsb_first ? sr_r[0] : sr_r[7];
    assign O_MISO = lsb_first ? sr_r[0] : sr_r[7];
    assign O_SS_N = pincfg_r[`SPIMSP_PIN_SS_LEVEL];
    assign O_SCK_OE_N = ~(en & master_select & pincfg_r[`SPIMSP_PIN_SCK_OUT]);
    assign O_MOSI_OE_N = ~(en & master_select & pincfg_r[`SPIMSP_PIN_MOSI_OUT]);
    assign O_MISO_OE_N = ~(en & ~master_select & ~ss_s & pincfg_r[`SPIMSP_PIN_MISO_OUT]);
    assign O_SS_OE_N = ~(en & master_select & pincfg_r[`SPIMSP_PIN_SS_OUT]);

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    // Cycles spent in the current master byte
    logic [10:0] mshift_cyc_r;

    always_ff @(posedge I_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            mshift_cyc_r <= 11'h000;
        end else if (st_r == SM_MSHIFT) begin
            mshift_cyc_r <= mshift_cyc_r + 11'h001;
        end else begin
            mshift_cyc_r <= 11'h000;
        end
    end

    default clocking cb @(posedge I_CLK);
    endclocking
    default disable iff (!I_NRST);

    chk_fault_master: assert property (mfault |=> !master_select && st_r == SM_IDLE)
        else $error("mode fault did not drop master");
    chk_fault_flag: assert property (mfault |=> done_r)
        else $error("mode fault did not set done flag");
    chk_ss_abort: assert property (st_r == SM_SLAVE && ss_s |=> st_r == SM_IDLE && edge_cnt_r == 4'h0)
        else $error("slave not reset by deselect");
    chk_disable_idle: assert property (!en |-> O_SCK_OE_N && O_MISO_OE_N ##1 st_r == SM_IDLE)
        else $error("disabled port still active");
    chk_done_set: assert property (complete |=> done_r && st_r != SM_MSHIFT)
        else $error("done flag missing after byte");
    chk_write_collision_flag_set: assert property (data_wr && busy |=> write_collision_flag_r && $stable(sr_r))
        else $error("collision not flagged");
    chk_status_zero: assert property (rd_take && I_AVS_ADDRESS == `SPIMSP_OFS_STATUS |-> O_AVS_READDATA[5:1] == 5'h00)
        else $error("reserved status bits not zero");
    chk_sck_idle: assert property (st_r == SM_IDLE && $stable(clock_polarity) |=> O_SCK == $past(clock_polarity))
        else $error("SCK not at idle level");
    chk_half_period: assert property (st_r == SM_MSHIFT && edge_ev && !last_edge |=> div_cnt_r == $past(half) - 7'h01)
        else $error("SCK half period wrong");
    chk_miso_drive: assert property (!O_MISO_OE_N |-> !ss_s && !master_select && en)
        else $error("MISO driven while not selected");
    chk_flag_clear: assert property (data_acc && arm_write_collision_flag_r && !complete && !mfault && !(data_wr && busy)
        |=> !done_r && !write_collision_flag_r)
        else $error("flags not cleared by access");
    chk_master_byte: assert property (st_r == SM_MSHIFT |-> mshift_cyc_r < `SPIMSP_MSHIFT_MAX)
        else $error("master byte never finished");

    cov_master_byte: cover property (st_r == SM_MSHIFT && complete);
    cov_slave_byte: cover property (st_r == SM_SLAVE && complete);
    cov_mode_fault: cover property (mfault);
    cov_collision: cover property (data_wr && busy);
endmodule

// File: tb/spimsp_peer.sv
// Far-end SPI device: slave while the port is master, master while it is slave
module spimsp_peer (
    input wire logic i_clk,
    input wire logic i_sck,
    input wire logic i_mosi,
    input wire logic i_miso,
    input wire logic i_clock_polarity,
    input wire logic i_clock_phase,
    input wire logic i_lsb,
    output logic o_miso,
    output logic o_sck,
    output logic o_mosi,
    output logic o_ss_n
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int half_clks = 6;
    logic [7:0] tx_r = 8'h00;
    logic [7:0] rx_r = 8'h00;
    int n = 0;
    initial begin
        o_sck = 1'b0;
        o_mosi = 1'b0;
        o_ss_n = 1'b1;
    end
    function automatic int bit_idx(input int i);
        return i_lsb ? i : 7 - i;
    endfunction
    ////////////////////////////////////////////////////////////////
    // Slave side, sampling edge from polarity and phase
    always @(posedge i_sck or negedge i_sck) begin
        if (i_sck ^ i_clock_polarity ^ i_clock_phase) begin
            if (n < 8) rx_r[bit_idx(n)] = i_mosi;
            n = n + 1;
        end
    end
    // After the byte the line no longer shows the last bit
    assign o_miso = (n < 8) ? tx_r[bit_idx(n)] : ~tx_r[bit_idx(7)];
    task automatic load(input logic [7:0] b);
        tx_r = b;
        n = 0;
    endtask
    ////////////////////////////////////////////////////////////////
    // Master side, each active SCK phase six clocks, each idle phase between bits seven
    task automatic select(input logic lvl);
        @(posedge i_clk);
        o_ss_n <= lvl;
        o_sck <= i_clock_polarity;
        if (lvl) o_mosi <= ~o_mosi;
        repeat (half_clks) @(posedge i_clk);
    endtask
    task automatic shift(input logic [7:0] b, input int nb, output logic [7:0] r);
        r = 8'h00;
        for (int i = 0; i < nb; i++) begin
            @(posedge i_clk);
            if (!i_clock_phase) o_mosi <= b[bit_idx(i)];
            repeat (half_clks) @(posedge i_clk);
            o_sck <= ~i_clock_polarity;
            if (i_clock_phase) o_mosi <= b[bit_idx(i)];
            else r[bit_idx(i)] = i_miso;
            repeat (half_clks) @(posedge i_clk);
            o_sck <= i_clock_polarity;
            if (i_clock_phase) r[bit_idx(i)] = i_miso;
        end
        repeat (half_clks) @(posedge i_clk);
    endtask
endmodule

// File: tb/spimsp_port_tb.sv
// Self-checking bench of the SPI port with a far-end device model
module spimsp_port_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import spimsp_pkg::*;
    localparam int half_tbl [8] = '{2, 8, 32, 64, 1, 4, 16, 32};
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [3:0] addr = 4'h0;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [3:0] be = 4'hf;
    logic ack = 1'b0;
    logic clock_polarity = 1'b0;
    logic clock_phase = 1'b0;
    logic lsb = 1'b0;
    logic [31:0] rdata;
    logic wreq, irq, sck_o, sck_oe_n, mosi_o, mosi_oe_n, miso_o, miso_oe_n, ss_o, ss_oe_n;
    logic p_sck, p_mosi, p_miso, p_ss;
    spimsp_byte_t rx_byte;
    logic [15:0] expq [$];
    logic [15:0] note;
    logic [7:0] last_rx = 8'h00;
    int failures = 0;
    int n_compared = 0;
    int hc = 0;
    wire logic sck_w = !sck_oe_n ? sck_o : p_sck;
    wire logic mosi_w = !mosi_oe_n ? mosi_o : p_mosi;
    wire logic miso_w = !miso_oe_n ? miso_o : p_miso;
    wire logic ss_w = !ss_oe_n ? ss_o : p_ss;

    spimsp_port dut (
        .I_CLK(clk), .I_NRST(nrst), .I_AVS_ADDRESS(addr), .I_AVS_READ(rd), .I_AVS_WRITE(wr),
        .I_AVS_WRITEDATA(wdata), .I_AVS_BYTEENABLE(be), .O_AVS_READDATA(rdata),
        .O_AVS_WAITREQUEST(wreq), .I_IRQ_ACK(ack), .O_IRQ(irq), .I_SCK(sck_w), .O_SCK(sck_o),
        .O_SCK_OE_N(sck_oe_n), .I_MOSI(mosi_w), .O_MOSI(mosi_o), .O_MOSI_OE_N(mosi_oe_n),
        .I_MISO(miso_w), .O_MISO(miso_o), .O_MISO_OE_N(miso_oe_n), .I_SS_N(ss_w), .O_SS_N(ss_o),
        .O_SS_OE_N(ss_oe_n), .O_RX_BYTE(rx_byte)
    );
    spimsp_peer peer (
        .i_clk(clk), .i_sck(sck_w), .i_mosi(mosi_w), .i_miso(miso_w), .i_clock_polarity(clock_polarity),
        .i_clock_phase(clock_phase), .i_lsb(lsb), .o_miso(p_miso), .o_sck(p_sck), .o_mosi(p_mosi), .o_ss_n(p_ss)
    );

    always #20 clk = ~clk;
    // Active SCK clocks, for the divider checks
    always @(posedge clk) begin
        if (sck_o !== clock_polarity) hc = hc + 1;
    end
    ////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t %s: got %h, expected %h", $time, what, got, exp);
        end
    endtask
    // Read results are compared here as they are taken
    always @(posedge clk) begin
        if (rd && !wreq) begin
            if (expq.size() == 0) begin
                chk(32'h1, 32'h0, "read without note");
            end else begin
                note = expq.pop_front();
                chk(rdata & {24'hffffff, note[7:0]}, {24'h0, note[15:8] & note[7:0]}, "read data");
            end
        end
    end
    task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d, input logic [7:0] msk = 8'hff,
                       input logic [3:0] lanes = 4'hf);
        int t;
        t = 0;
        @(posedge clk);
        wr <= w;
        rd <= !w;
        addr <= a;
        wdata <= {24'h0, d};
        be <= lanes;
        if (!w) expq.push_back({d, msk});
        do begin
            @(negedge clk);
            t++;
        end while (wreq !== 1'b0 && t < 200);
        chk(t < 200, 1, "bus answer");
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b0;
    endtask
    task automatic wait_irq(input logic lvl);
        int t;
        t = 0;
        do begin
            @(negedge clk);
            t++;
        end while (irq !== lvl && t < 3000);
        chk(irq, lvl, "interrupt line");
    endtask
    task automatic done_test(input string s);
        $display("test done: %s", s);
    endtask
    task automatic summarize();
        $display("compared %0d, mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    // Master transfer; i picks mode, bit order and rate
    task automatic mxfer(input int i, input logic col);
        logic [7:0] ptx, dtx;
        ptx = $urandom;
        dtx = $urandom;
        clock_polarity = i[0];
        clock_phase = i[1];
        lsb = i[2];
        bus(1, 4'hc, 8'h0e);
        bus(1, 4'h4, {7'h0, i[2]});
        bus(1, 4'h0, {2'b11, lsb, 1'b1, clock_polarity, clock_phase, i[1:0]});
        repeat (2) @(negedge clk);
        chk(sck_o, clock_polarity, "sck idle level");
        chk(ss_o, 0, "ss as output");
        chk(ss_oe_n, 0, "ss driven");
        peer.load(ptx);
        hc = 0;
        bus(1, 4'h8, dtx);
        if (col) bus(1, 4'h8, ~dtx);
        wait_irq(1'b1);
        chk(hc, 8 * half_tbl[i], "sck active clocks");
        bus(0, 4'h4, {1'b1, col, 5'h0, i[2]});
        bus(0, 4'h8, ptx);
        chk(rx_byte, ptx, "rx byte port");
        chk(peer.rx_r, dtx, "far end byte");
        bus(0, 4'h4, {7'h0, i[2]});
        last_rx = ptx;
        done_test("master transfer");
    endtask

    initial begin
        logic [7:0] b, stx, ptx, r;
        void'($urandom(32'h9d453d90));
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        for (int k = 0; k < 16; k += 2) bus(0, k[3:0], 8'h00);
        bus(1, 4'h2, 8'hff);
        bus(1, 4'h0, 8'hff, 8'hff, 4'he);
        bus(0, 4'h0, 8'h00);
        bus(1, 4'h4, 8'hff);
        bus(0, 4'h4, 8'h01);
        bus(1, 4'h4, 8'h00);
        done_test("register reset and map");
        bus(1, 4'hc, 8'h0e);
        bus(1, 4'h0, 8'h10);
        hc = 0;
        bus(1, 4'h8, 8'h5a);
        repeat (300) @(negedge clk);
        chk(hc, 0, "sck while disabled");
        chk(sck_oe_n, 1, "sck drive while disabled");
        bus(0, 4'h4, 8'h00);
        done_test("port disabled");
        for (int i = 0; i < 8; i++) mxfer(i, 1'b0);
        mxfer(3, 1'b1);
        bus(1, 4'hc, 8'h06);
        bus(1, 4'h0, 8'hd0);
        @(negedge clk);
        chk(sck_oe_n, 0, "master drives sck");
        peer.select(1'b0);
        chk(sck_oe_n, 1, "sck released on fault");
        chk(mosi_oe_n, 1, "mosi released on fault");
        chk(irq, 1, "fault interrupt");
        bus(0, 4'h0, 8'hc0);
        bus(0, 4'h4, 8'h80);
        bus(1, 4'h0, 8'h40);
        @(negedge clk);
        chk(irq, 0, "masked interrupt");
        bus(1, 4'h0, 8'hc0);
        @(negedge clk);
        chk(irq, 1, "unmasked interrupt");
        @(posedge clk);
        ack <= 1'b1;
        @(posedge clk);
        ack <= 1'b0;
        @(negedge clk);
        chk(irq, 0, "vector clears flag");
        bus(0, 4'h4, 8'h00);
        peer.select(1'b1);
        bus(1, 4'h0, 8'hd0);
        @(negedge clk);
        chk(sck_oe_n, 0, "master resumed");
        done_test("mode fault");
        b = $urandom;
        stx = $urandom;
        ptx = $urandom;
        clock_polarity = b[0];
        clock_phase = b[1];
        lsb = b[2];
        bus(1, 4'hc, 8'h01);
        bus(1, 4'h0, {2'b11, lsb, 1'b0, clock_polarity, clock_phase, b[4:3]});
        peer.select(1'b1);
        bus(1, 4'h8, stx);
        chk(miso_oe_n, 1, "miso idle while deselected");
        peer.select(1'b0);
        chk(miso_oe_n, 0, "miso driven when selected");
        chk(sck_oe_n & mosi_oe_n, 1, "slave inputs");
        peer.shift(~ptx, 3, r);
        peer.select(1'b1);
        chk(irq, 0, "partial byte");
        bus(0, 4'h8, last_rx);
        bus(1, 4'h8, stx);
        peer.select(1'b0);
        peer.shift(ptx, 8, r);
        peer.select(1'b1);
        wait_irq(1'b1);
        chk(r, stx, "slave sent byte");
        bus(0, 4'h4, 8'h80);
        bus(0, 4'h8, ptx);
        done_test("slave transfer");
        summarize();
    end
    initial begin
        repeat (20000) @(posedge clk);
        chk(32'h0, 32'h1, "watchdog");
        summarize();
    end
endmodule
